// *** verilog/ssxr_pkg.sv ***
package ssxr_pkg;

	// Opcodes (values chosen for this block; the fast read code is fixed)
	localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OPC_WRITE = 8'h02;
	localparam logic [7:0] OPC_DUAL_DATA_WRITE = 8'hA2;
	localparam logic [7:0] OPC_FOUR_DATA_WRITE = 8'h32;
	localparam logic [7:0] OPC_DUAL_ADDR_DATA_WRITE = 8'hA1;
	localparam logic [7:0] OPC_FOUR_ADDR_DATA_WRITE = 8'hD2;
	localparam logic [7:0] OPC_FAST_READ = 8'h0B;
	localparam logic [7:0] OPC_DUAL_OUTPUT_READ = 8'h3B;
	localparam logic [7:0] OPC_FOUR_OUTPUT_READ = 8'h6B;
	localparam logic [7:0] OPC_DUAL_IO_READ = 8'hBB;
	localparam logic [7:0] OPC_FOUR_IO_READ = 8'hEB;
	localparam logic [7:0] OPC_RESET_ARM = 8'h66;
	localparam logic [7:0] OPC_RESET = 8'h99;
	localparam logic [7:0] OPC_ENTER_SINGLE = 8'hFF;
	localparam logic [7:0] OPC_ENTER_DUAL = 8'h37;
	localparam logic [7:0] OPC_ENTER_FOUR = 8'h38;

	// Frame layout
	localparam int ADDR_W = 17;
	localparam logic [16:0] ADDR_TOP = 17'h1FFFF;
	localparam logic [16:0] ADDR_ZERO = 17'h00000;
	localparam logic [4:0] BYTE_BITS = 5'h08;
	localparam logic [4:0] ADDR_FIELD_BITS = 5'h18;
	localparam logic [3:0] MODE_STAY = 4'hA;
	localparam logic [3:0] OE_SINGLE = 4'h2;
	localparam logic [3:0] OE_DUAL = 4'h3;
	localparam logic [3:0] OE_FOUR = 4'hF;

	typedef enum logic [1:0] {LN_SINGLE, LN_DUAL, LN_FOUR} ssxr_lane_e;
	typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_MODE, ST_RDATA, ST_WDATA,
		ST_IGNORE} ssxr_state_e;

endpackage

// *** verilog/ssxr_top.sv ***
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Burst write increments, wraps top to zero
// - Write latch stays set after writes
// - Protected addresses advance but discard data
// - Three address bytes, seventeen bits used
// - Write data follows address directly, MSB first
// - Single lane write on serial input
// - Dual lane write, bit 7 on lane 1
// - Four lane write, bit 7 on lane 3
// - Dual data write: serial head, two-lane data
// - Four data write: serial head, four-lane data
// - Dual address-data write after serial opcode
// - Four address-data write after serial opcode
// - Continuous read only for listed reads
// - Mode nibble A keeps continuous read
// - Mode byte lower nibble ignored
// - Reset acts only right after arm
// - Soft reset: single lane, volatile bits cleared
// - Arm and reset ignored while write busy
// - Four-lane enable turns protect/spare into lanes
// - Reads carry mode byte before data
module ssxr_top
	import ssxr_pkg::*;
(
	// Clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RSTN,
	// Serial link
	input wire logic I_SCK,
	input wire logic I_CS_N,
	input wire logic [3:0] I_IO_IN,
	output logic [3:0] O_IO_OUT,
	output logic [3:0] O_IO_OE,
	// Configuration and status
	input wire logic I_FOUR_LANE_EN,
	input wire logic I_WRITE_IN_PROGRESS,
	input wire logic I_PROT_EN,
	input wire logic [ADDR_W-1:0] I_PROT_LO,
	input wire logic [ADDR_W-1:0] I_PROT_HI,
	output logic O_WRITE_ENABLE_LATCH,
	output logic O_CONTINUOUS_READ,
	output logic [1:0] O_LANE_MODE,
	output logic O_RESET_ARMED,
	output logic O_SOFT_RESET,
	output logic O_WP_N,
	// Memory array port
	output logic [ADDR_W-1:0] O_MEM_RADDR,
	input wire logic [7:0] I_MEM_RDATA,
	output logic O_MEM_WE,
	output logic [ADDR_W-1:0] O_MEM_WADDR,
	output logic [7:0] O_MEM_WDATA
);

	typedef struct packed {
		logic sck1, sck2, sck3;
		logic cs1, cs2;
		logic [3:0] io1, io2;
		ssxr_state_e st;
		logic [23:0] sh;
		logic [4:0] cnt;
		ssxr_lane_e lw_addr, lw_data;
		logic is_read;
		logic [ADDR_W-1:0] addr;
		logic [7:0] out_sh;
		logic [3:0] io_out, io_oe;
		ssxr_lane_e mode;
		logic write_enable_latch, continuous_read_mode;
		ssxr_lane_e xip_la, xip_ld;
		logic armed, srst, we;
		logic [ADDR_W-1:0] waddr;
		logic [7:0] wdata;
		logic wp_n;
	} ssxr_reg_s;

	////////////////////////////////////////////////////////////////////////////
	// Reset release
	logic [1:0] rst_sync;
	logic rst_n;
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [4:0] lane_bits(input ssxr_lane_e l);
		case (l)
			LN_SINGLE: lane_bits = 5'h01;
			LN_DUAL: lane_bits = 5'h02;
			default: lane_bits = 5'h04;
		endcase
	endfunction
	function automatic logic [23:0] shift_in(input logic [23:0] s, input logic [3:0] io,
		input ssxr_lane_e l);
		case (l)
			LN_SINGLE: shift_in = {s[22:0], io[0]};
			LN_DUAL: shift_in = {s[21:0], io[1:0]};
			default: shift_in = {s[19:0], io[3:0]};
		endcase
	endfunction
	function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
		next_addr = (a == ADDR_TOP) ? ADDR_ZERO : a + 17'h00001;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Command engine
	ssxr_reg_s r;
	ssxr_reg_s n;
	always_comb begin
		logic rise, fall, ok, four_cmd;
		logic [23:0] sh_in;
		logic [4:0] cnt_in;
		logic [7:0] ob, b;
		rise = r.sck2 & ~r.sck3;
		fall = ~r.sck2 & r.sck3;
		sh_in = 24'h000000;
		cnt_in = 5'h00;
		ob = 8'h00;
		b = 8'h00;
		ok = 1'b0;
		four_cmd = 1'b0;
		n = r;
		n.we = 1'b0;
		n.srst = 1'b0;
		n.sck1 = I_SCK;
		n.sck2 = r.sck1;
		n.sck3 = r.sck2;
		n.cs1 = I_CS_N;
		n.cs2 = r.cs1;
		n.io1 = I_IO_IN;
		n.io2 = r.io1;
		n.wp_n = I_FOUR_LANE_EN ? 1'b1 : r.io2[2];
		if (r.cs2) begin
			n.st = ST_IDLE;
			n.io_oe = 4'h0;
			n.cnt = 5'h00;
		end else begin
			case (r.st)
				ST_IDLE: begin
					n.cnt = 5'h00;
					n.sh = 24'h000000;
					if (r.continuous_read_mode) begin
						n.st = ST_ADDR;
						n.is_read = 1'b1;
						n.lw_addr = r.xip_la;
						n.lw_data = r.xip_ld;
					end else begin
						n.st = ST_OPC;
					end
				end
				ST_OPC: begin
					if (rise) begin
						sh_in = shift_in(r.sh, r.io2, r.mode);
						cnt_in = r.cnt + lane_bits(r.mode);
						n.sh = sh_in;
						n.cnt = cnt_in;
						if (cnt_in == BYTE_BITS) begin
							b = sh_in[7:0];
							n.cnt = 5'h00;
							n.sh = 24'h000000;
							n.armed = 1'b0;
							n.lw_addr = r.mode;
							n.lw_data = r.mode;
							n.is_read = 1'b0;
							case (b)
								OPC_WRITE_ENABLE: n.write_enable_latch = 1'b1;
								OPC_WRITE_DISABLE: n.write_enable_latch = 1'b0;
								OPC_RESET_ARM: n.armed = r.armed | ~I_WRITE_IN_PROGRESS;
								OPC_RESET: begin
									n.armed = I_WRITE_IN_PROGRESS & r.armed;
									n.srst = r.armed & ~I_WRITE_IN_PROGRESS;
									n.mode = n.srst ? LN_SINGLE : r.mode;
									n.write_enable_latch = r.write_enable_latch & ~n.srst;
									n.continuous_read_mode = r.continuous_read_mode & ~n.srst;
								end
								OPC_ENTER_SINGLE: n.mode = LN_SINGLE;
								OPC_ENTER_DUAL: n.mode = LN_DUAL;
								OPC_ENTER_FOUR: n.mode = LN_FOUR;
								OPC_WRITE, OPC_FAST_READ: begin
									ok = 1'b1;
									n.is_read = (b == OPC_FAST_READ);
									four_cmd = (r.mode == LN_FOUR);
								end
								OPC_DUAL_DATA_WRITE, OPC_DUAL_OUTPUT_READ: begin
									ok = (r.mode == LN_SINGLE);
									n.is_read = (b == OPC_DUAL_OUTPUT_READ);
									n.lw_data = LN_DUAL;
								end
								OPC_FOUR_DATA_WRITE, OPC_FOUR_OUTPUT_READ: begin
									ok = (r.mode == LN_SINGLE);
									four_cmd = 1'b1;
									n.is_read = (b == OPC_FOUR_OUTPUT_READ);
									n.lw_data = LN_FOUR;
								end
								OPC_DUAL_ADDR_DATA_WRITE, OPC_DUAL_IO_READ: begin
									ok = (r.mode == LN_SINGLE);
									n.is_read = (b == OPC_DUAL_IO_READ);
									n.lw_addr = LN_DUAL;
									n.lw_data = LN_DUAL;
								end
								OPC_FOUR_ADDR_DATA_WRITE, OPC_FOUR_IO_READ: begin
									ok = (r.mode == LN_SINGLE);
									four_cmd = 1'b1;
									n.is_read = (b == OPC_FOUR_IO_READ);
									n.lw_addr = LN_FOUR;
									n.lw_data = LN_FOUR;
								end
								default: ok = 1'b0;
							endcase
							ok = ok & ~(four_cmd & ~I_FOUR_LANE_EN);
							ok = ok & (n.is_read | r.write_enable_latch);
							n.st = ok ? ST_ADDR : ST_IGNORE;
						end
					end
				end
				ST_ADDR: begin
					if (rise) begin
						sh_in = shift_in(r.sh, r.io2, r.lw_addr);
						cnt_in = r.cnt + lane_bits(r.lw_addr);
						n.sh = sh_in;
						n.cnt = cnt_in;
						if (cnt_in == ADDR_FIELD_BITS) begin
							n.addr = sh_in[ADDR_W-1:0];
							n.cnt = 5'h00;
							n.sh = 24'h000000;
							n.st = r.is_read ? ST_MODE : ST_WDATA;
						end
					end
				end
				ST_MODE: begin
					if (rise) begin
						sh_in = shift_in(r.sh, r.io2, r.lw_addr);
						cnt_in = r.cnt + lane_bits(r.lw_addr);
						n.sh = sh_in;
						n.cnt = cnt_in;
						if (cnt_in == BYTE_BITS) begin
							n.continuous_read_mode = (sh_in[7:4] == MODE_STAY);
							n.xip_la = r.lw_addr;
							n.xip_ld = r.lw_data;
							n.cnt = 5'h00;
							n.st = ST_RDATA;
						end
					end
				end
				ST_RDATA: begin
					if (fall) begin
						ob = (r.cnt == 5'h00) ? I_MEM_RDATA : r.out_sh;
						n.io_out = 4'h0;
						case (r.lw_data)
							LN_SINGLE: begin
								n.io_out[1] = ob[7];
								n.io_oe = OE_SINGLE;
							end
							LN_DUAL: begin
								n.io_out[1:0] = ob[7:6];
								n.io_oe = OE_DUAL;
							end
							default: begin
								n.io_out = ob[7:4];
								n.io_oe = OE_FOUR;
							end
						endcase
						n.out_sh = 8'(ob << lane_bits(r.lw_data));
						cnt_in = r.cnt + lane_bits(r.lw_data);
						n.cnt = cnt_in;
						if (cnt_in == BYTE_BITS) begin
							n.cnt = 5'h00;
							n.addr = next_addr(r.addr);
						end
					end
				end
				ST_WDATA: begin
					if (rise) begin
						sh_in = shift_in(r.sh, r.io2, r.lw_data);
						cnt_in = r.cnt + lane_bits(r.lw_data);
						n.sh = sh_in;
						n.cnt = cnt_in;
						if (cnt_in == BYTE_BITS) begin
							n.cnt = 5'h00;
							n.wdata = sh_in[7:0];
							n.waddr = r.addr;
							n.we = ~(I_PROT_EN && r.addr >= I_PROT_LO && r.addr <= I_PROT_HI);
							n.addr = next_addr(r.addr);
						end
					end
				end
				ST_IGNORE: n.cnt = 5'h00;
				default: n.st = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.cs1 <= 1'b1;
			r.cs2 <= 1'b1;
			r.wp_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign O_IO_OUT = r.io_out;
	assign O_IO_OE = r.io_oe;
	assign O_WRITE_ENABLE_LATCH = r.write_enable_latch;
	assign O_CONTINUOUS_READ = r.continuous_read_mode;
	assign O_LANE_MODE = r.mode;
	assign O_RESET_ARMED = r.armed;
	assign O_SOFT_RESET = r.srst;
	assign O_WP_N = r.wp_n;
	assign O_MEM_RADDR = r.addr;
	assign O_MEM_WE = r.we;
	assign O_MEM_WADDR = r.waddr;
	assign O_MEM_WDATA = r.wdata;

endmodule // ssxr_top

`default_nettype wire

// *** verif/ssxr_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module ssxr_properties
	import ssxr_pkg::*;
(
	// Inputs
	input wire logic I_CLK_SYS,
	input wire logic I_RSTN,
	input wire logic I_SCK,
	input wire logic I_CS_N,
	input wire logic I_FOUR_LANE_EN,
	input wire logic I_WRITE_IN_PROGRESS,
	input wire logic I_PROT_EN,
	input wire logic [ADDR_W-1:0] I_PROT_LO,
	input wire logic [ADDR_W-1:0] I_PROT_HI,
	// Outputs
	input wire logic [3:0] O_IO_OUT,
	input wire logic O_WRITE_ENABLE_LATCH,
	input wire logic O_CONTINUOUS_READ,
	input wire logic [1:0] O_LANE_MODE,
	input wire logic O_RESET_ARMED,
	input wire logic O_SOFT_RESET,
	input wire logic O_WP_N,
	input wire logic O_MEM_WE,
	input wire logic [ADDR_W-1:0] O_MEM_WADDR
);
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RSTN);
	logic [ADDR_W-1:0] last;
	logic seen;
	// Remembers the previous write of the same frame
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			seen <= 1'b0;
			last <= ADDR_ZERO;
		end else begin
			seen <= !I_CS_N && (seen || O_MEM_WE);
			if (O_MEM_WE) begin
				last <= O_MEM_WADDR;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	we_latch_a: assert property (O_MEM_WE |-> O_WRITE_ENABLE_LATCH)
		else $error("write with latch clear");
	latch_keep_a: assert property (O_MEM_WE |=> O_WRITE_ENABLE_LATCH [*8])
		else $error("latch dropped after write");
	burst_next_a: assert property (O_MEM_WE && seen && !I_PROT_EN |-> O_MEM_WADDR == ADDR_W'(last + 17'h00001))
		else $error("burst address not next");
	prot_skip_a: assert property (O_MEM_WE && I_PROT_EN |-> O_MEM_WADDR < I_PROT_LO || O_MEM_WADDR > I_PROT_HI)
		else $error("protected address written");
	rst_clear_a: assert property (O_SOFT_RESET |=> !O_WRITE_ENABLE_LATCH && !O_CONTINUOUS_READ && O_LANE_MODE == 2'h0)
		else $error("soft reset left state");
	rst_armed_a: assert property ($rose(O_SOFT_RESET) |-> $past(O_RESET_ARMED))
		else $error("soft reset without arm");
	busy_ign_a: assert property (I_WRITE_IN_PROGRESS |-> !$rose(O_RESET_ARMED) && !O_SOFT_RESET)
		else $error("arm or reset while busy");
	wp_quad_a: assert property (I_FOUR_LANE_EN [*3] |-> O_WP_N)
		else $error("protect pin active in four lane");
	out_fall_a: assert property (!I_CS_N && $changed(O_IO_OUT) |-> !$past(I_SCK, 2))
		else $error("output moved after rising edge");
	cover property (O_MEM_WE && O_MEM_WADDR == ADDR_ZERO);
	cover property ($rose(O_CONTINUOUS_READ));
	cover property (O_SOFT_RESET);
endmodule // ssxr_properties
`default_nettype wire

// *** verif/ssxr_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module ssxr_host (
	// Link
	output logic o_sck,
	output logic o_cs_n,
	output logic [3:0] o_io,
	input wire logic [3:0] i_io
);
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_io = 4'h0;
	end
	// Idle lanes show the inverse of their last value
	task automatic put(input logic [7:0] b, input int w);
		for (int i = 8 - w; i >= 0; i -= w) begin
			o_io = ~o_io;
			case (w)
				1: o_io[0] = b[i];
				2: o_io[1:0] = b[i+:2];
				default: o_io = b[i+:4];
			endcase
			#200 o_sck = 1'b1;
			#200 o_sck = 1'b0;
		end
	endtask
	task automatic get(output logic [7:0] b, input int w);
		for (int i = 8 - w; i >= 0; i -= w) begin
			o_io = ~o_io;
			#400 o_sck = 1'b1;
			case (w)
				1: b[i] = i_io[1];
				2: b[i+:2] = i_io[1:0];
				default: b[i+:4] = i_io;
			endcase
			#200 o_sck = 1'b0;
		end
	endtask
	task automatic adr(input logic [16:0] a, input int w);
		put({7'h7F, a[16]}, w);
		put(a[15:8], w);
		put(a[7:0], w);
	endtask
	task automatic sel();
		o_cs_n = 1'b0;
		#300;
	endtask
	task automatic desel();
		#300 o_cs_n = 1'b1;
		#600;
	endtask
	task automatic cmd(input logic [7:0] op, input int w);
		sel();
		put(op, w);
		desel();
	endtask
endmodule // ssxr_host
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import ssxr_pkg::*;
	typedef struct {logic [7:0] pre; int wp; logic [7:0] op; int wo, wa, wd; logic [16:0] a;} ssxr_row_s;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic sck, cs_n, we, write_enable_latch, cr, armed, srst, wpn;
	logic four = 1'b1;
	logic write_in_progress_bit = 1'b0;
	logic pen = 1'b0;
	logic [3:0] hio, dout, doe, io;
	logic [1:0] lane;
	logic [16:0] raddr, waddr;
	logic [7:0] wdata, rd;
	logic [7:0] mem [0:131071];
	logic [24:0] wq [$];
	int num_errors = 0;
	int n_checks = 0;
	int nrst = 0;
	ssxr_row_s rows [8] = '{
		'{8'h00, 1, OPC_WRITE, 1, 1, 1, 17'h1FFFF},
		'{8'h00, 1, OPC_DUAL_DATA_WRITE, 1, 1, 2, 17'h00110},
		'{8'h00, 1, OPC_FOUR_DATA_WRITE, 1, 1, 4, 17'h10120},
		'{8'h00, 1, OPC_DUAL_ADDR_DATA_WRITE, 1, 2, 2, 17'h00130},
		'{8'h00, 1, OPC_FOUR_ADDR_DATA_WRITE, 1, 4, 4, 17'h00140},
		'{OPC_ENTER_DUAL, 1, OPC_WRITE, 2, 2, 2, 17'h00150},
		'{OPC_ENTER_FOUR, 2, OPC_WRITE, 4, 4, 4, 17'h00160},
		'{OPC_ENTER_SINGLE, 4, OPC_WRITE, 1, 1, 1, 17'h00170}};
	assign io = (doe & dout) | (~doe & hio);
	always #25 clk = ~clk;
	ssxr_top i_ssxr_top (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_SCK(sck), .I_CS_N(cs_n),
		.I_IO_IN(io), .O_IO_OUT(dout), .O_IO_OE(doe), .I_FOUR_LANE_EN(four),
		.I_WRITE_IN_PROGRESS(write_in_progress_bit), .I_PROT_EN(pen), .I_PROT_LO(17'h00301), .I_PROT_HI(17'h00301),
		.O_WRITE_ENABLE_LATCH(write_enable_latch), .O_CONTINUOUS_READ(cr), .O_LANE_MODE(lane),
		.O_RESET_ARMED(armed), .O_SOFT_RESET(srst), .O_WP_N(wpn), .O_MEM_RADDR(raddr),
		.I_MEM_RDATA(mem[raddr]), .O_MEM_WE(we), .O_MEM_WADDR(waddr), .O_MEM_WDATA(wdata));
	ssxr_host i_ssxr_host (.o_sck(sck), .o_cs_n(cs_n), .o_io(hio), .i_io(io));
	always @(posedge clk) begin
		nrst <= nrst + (srst === 1'b1);
		if (we === 1'b1) begin
			mem[waddr] <= wdata;
			wq.push_back({waddr, wdata});
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] op, input int wo, wa, wd, input logic [16:0] a, input int n);
		logic [16:0] p;
		i_ssxr_host.sel();
		i_ssxr_host.put(op, wo);
		i_ssxr_host.adr(a, wa);
		for (int k = 0; k < n; k++) begin
			p = 17'(a + k);
			i_ssxr_host.put(p[7:0] ^ 8'h5A, wd);
		end
		i_ssxr_host.desel();
	endtask
	task automatic got(input logic [16:0] a);
		logic [24:0] e;
		e = {a, a[7:0] ^ 8'h5A};
		if (wq.size() == 0) wq.push_back(~e);
		chk(wq.pop_front(), e);
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		foreach (rows[r]) begin
			if (rows[r].pre !== 8'h00) i_ssxr_host.cmd(rows[r].pre, rows[r].wp);
			i_ssxr_host.cmd(OPC_WRITE_ENABLE, rows[r].wo);
			wr(rows[r].op, rows[r].wo, rows[r].wa, rows[r].wd, rows[r].a, 2);
			got(rows[r].a);
			got(17'(rows[r].a + 1));
		end
		chk(write_enable_latch, 1);
		i_ssxr_host.cmd(OPC_WRITE_DISABLE, 1);
		wr(OPC_WRITE, 1, 1, 1, 17'h00200, 1);
		chk(wq.size(), 0);
		@(posedge clk) #1 pen = 1'b1;
		i_ssxr_host.cmd(OPC_WRITE_ENABLE, 1);
		wr(OPC_WRITE, 1, 1, 1, 17'h00300, 3);
		got(17'h00300);
		got(17'h00302);
		@(posedge clk) #1 pen = 1'b0;
		i_ssxr_host.sel();
		i_ssxr_host.put(OPC_FAST_READ, 1);
		i_ssxr_host.adr(17'h00110, 1);
		i_ssxr_host.put(8'hAC, 1);
		i_ssxr_host.get(rd, 1);
		i_ssxr_host.desel();
		chk(rd, 8'h4A);
		chk(cr, 1);
		i_ssxr_host.sel();
		i_ssxr_host.adr(17'h00111, 1);
		i_ssxr_host.put(8'h5F, 1);
		i_ssxr_host.get(rd, 1);
		i_ssxr_host.desel();
		chk(rd, 8'h4B);
		chk(cr, 0);
		i_ssxr_host.sel();
		i_ssxr_host.put(OPC_DUAL_IO_READ, 1);
		i_ssxr_host.adr(17'h00130, 2);
		i_ssxr_host.put(8'h00, 2);
		i_ssxr_host.get(rd, 2);
		i_ssxr_host.desel();
		chk(rd, 8'h6A);
		i_ssxr_host.sel();
		i_ssxr_host.put(OPC_FOUR_IO_READ, 1);
		i_ssxr_host.adr(17'h00140, 4);
		i_ssxr_host.put(8'h00, 4);
		i_ssxr_host.get(rd, 4);
		i_ssxr_host.desel();
		chk(rd, 8'h1A);
		chk(cr, 0);
		@(posedge clk) #1 write_in_progress_bit = 1'b1;
		i_ssxr_host.cmd(OPC_RESET_ARM, 1);
		chk(armed, 0);
		@(posedge clk) #1 write_in_progress_bit = 1'b0;
		i_ssxr_host.cmd(OPC_RESET_ARM, 1);
		@(posedge clk) #1 write_in_progress_bit = 1'b1;
		i_ssxr_host.cmd(OPC_RESET, 1);
		chk(nrst, 0);
		chk(armed, 1);
		@(posedge clk) #1 write_in_progress_bit = 1'b0;
		i_ssxr_host.cmd(OPC_ENTER_DUAL, 1);
		i_ssxr_host.cmd(OPC_RESET_ARM, 2);
		chk(armed, 1);
		i_ssxr_host.cmd(OPC_WRITE_ENABLE, 2);
		chk({armed, write_enable_latch}, 1);
		i_ssxr_host.cmd(OPC_RESET_ARM, 2);
		i_ssxr_host.cmd(OPC_RESET, 2);
		chk(nrst, 1);
		chk({lane, write_enable_latch, cr}, 0);
		i_ssxr_host.cmd(OPC_WRITE_ENABLE, 1);
		@(posedge clk) #1 four = 1'b0;
		i_ssxr_host.cmd(8'h00, 4);
		chk(wpn, 0);
		wr(OPC_FOUR_DATA_WRITE, 1, 1, 4, 17'h00400, 1);
		chk(wq.size(), 0);
		four = 1'b1;
		@(posedge clk) #1 chk(wpn, 1);
		@(posedge clk) #1 rstn = 1'b0;
		repeat (2) @(posedge clk);
		#1 chk({write_enable_latch, cr, lane, armed, srst, we, wpn}, 1);
		rstn = 1'b1;
		repeat (4) @(posedge clk);
		report_and_stop();
	end
endmodule // tb_top
bind ssxr_top ssxr_properties i_ssxr_properties (.I_CLK_SYS, .I_RSTN, .I_SCK, .I_CS_N,
	.I_FOUR_LANE_EN, .I_WRITE_IN_PROGRESS, .I_PROT_EN, .I_PROT_LO, .I_PROT_HI, .O_IO_OUT,
	.O_WRITE_ENABLE_LATCH, .O_CONTINUOUS_READ, .O_LANE_MODE, .O_RESET_ARMED, .O_SOFT_RESET,
	.O_WP_N, .O_MEM_WE, .O_MEM_WADDR);
`default_nettype wire
